// File: include/xtse_consts.vh
// Constants for the exclusive-OR, tristate-load and subtract execution slice.
`ifndef XTSE_CONSTS_VH
`define XTSE_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------------------
`define XTSE_OFF_WREG        8'h00
`define XTSE_OFF_INSTR       8'h04
`define XTSE_OFF_STATUS      8'h08
`define XTSE_OFF_TRIS5       8'h0c
`define XTSE_OFF_TRIS6       8'h10
`define XTSE_OFF_TRIS7       8'h14
`define XTSE_OFF_FILE_LO     8'h40
`define XTSE_OFF_FILE_HI     8'hbc

// ----------------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------------
`define XTSE_ST_CARRY        0
`define XTSE_ST_DCARRY       1
`define XTSE_ST_ZERO         2
`define XTSE_ST_UNSUP        7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define XTSE_RST_WREG        8'h00
`define XTSE_RST_STATUS      8'h00
`define XTSE_RST_DIR         8'hff
`define XTSE_RST_FILE        8'h00

// ----------------------------------------------------------------------------
// Instruction encodings
// ----------------------------------------------------------------------------
`define XTSE_OP_XLIT_HI      4'hf
`define XTSE_OP_XFILE_HI     6'h06
`define XTSE_OP_SUB_HI       6'h02
`define XTSE_OP_DIRLD_HI     9'h000
`define XTSE_DIR_SEL_LO      3'h5
`define XTSE_DIR_SEL_HI      3'h7

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define XTSE_RESP_OKAY       2'h0
`define XTSE_RESP_SLVERR     2'h2

`endif

// File: rtl/xtse_exec.v
// Execution slice for four instructions behind an AXI4-Lite register slave.
`timescale 1ns/100ps
`include "xtse_consts.vh"
// Operation
// - Subtract computes file minus working register, two's complement, to chosen destination.
// - Subtract sets carry when result is zero or positive, clears it on borrow.
// - Tristate load takes selector 5, 6 or 7 only, copies whole working register.
// - Tristate load is a 12-bit word with upper nine bits zero, selector low.
// - Literal XOR combines working register with 8-bit immediate, result to working register.
// - File XOR combines working register with file register picked by 5-bit field.
// - File XOR result goes to working register if destination bit 0, else file.
// - Both XOR forms update zero flag and clear unsupported flag, carry and digit carry untouched.
module xtse_exec (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [7:0]  tris5_dir,
  output wire [7:0]  tris6_dir,
  output wire [7:0]  tris7_dir
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------

  // True when the word address falls inside the file register window.
  function is_file;
    input [7:0] addr;
    begin
      is_file = (addr >= `XTSE_OFF_FILE_LO) && (addr <= `XTSE_OFF_FILE_HI);
    end
  endfunction

  // True for any address that maps to a register; used by both read and write.
  // Keeping it one function means a read and a write can never disagree about the map.
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = is_file(addr) || (addr == `XTSE_OFF_WREG) || (addr == `XTSE_OFF_INSTR) ||
                  (addr == `XTSE_OFF_STATUS) || (addr == `XTSE_OFF_TRIS5) ||
                  (addr == `XTSE_OFF_TRIS6) || (addr == `XTSE_OFF_TRIS7);
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  // Each register is one byte in lane 0 of its word: working register, instruction
  // (write only, reads zero), status, three direction registers, then 32 file registers.
  // Status holds carry in bit 0, digit carry in bit 1 and zero in bit 2; bit 7 records
  // that the last issued word matched none of the four forms, so software can see a
  // word that was silently ignored.
  reg  [7:0]  wreg_q;
  reg  [7:0]  status_q;
  reg  [7:0]  tris5_q;
  reg  [7:0]  tris6_q;
  reg  [7:0]  tris7_q;
  reg  [7:0]  file_q [0:31];
  reg         aw_have_q;
  reg         w_have_q;
  reg  [7:0]  waddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  integer     i;

  // --------------------------------------------------------------------------
  // Write channel handshakes
  // --------------------------------------------------------------------------

  // Address and data are caught independently so the master may offer them in either order.
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // The response rises one edge after both halves are held and the store lands on that
  // same edge, so a read issued after the response always sees the new value.
  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        do_wr   = aw_have_q & w_have_q & ~bvalid_q;
  wire [7:0]  wa      = {waddr_q[7:2], 2'b00};
  wire [4:0]  wfile   = wa[6:2] - 5'h10;

  // --------------------------------------------------------------------------
  // Instruction decode and execute
  // --------------------------------------------------------------------------

  // A full low halfword is needed to issue; a partial write cannot form an instruction.
  wire        issue   = do_wr & (wa == `XTSE_OFF_INSTR) & wstrb_q[0] & wstrb_q[1];
  wire [11:0] instr   = wdata_q[11:0];
  wire [4:0]  fsel    = instr[4:0];
  wire        dsel    = instr[5];
  wire [7:0]  fval    = file_q[fsel];
  wire        op_xlw  = (instr[11:8] == `XTSE_OP_XLIT_HI);
  wire        op_xwf  = (instr[11:6] == `XTSE_OP_XFILE_HI);
  wire        op_sub  = (instr[11:6] == `XTSE_OP_SUB_HI);
  // Selectors below five fall through to the unsupported flag instead of loading a
  // direction register that does not exist.
  wire        op_dir  = (instr[11:3] == `XTSE_OP_DIRLD_HI) &
                        (instr[2:0] >= `XTSE_DIR_SEL_LO) &
                        (instr[2:0] <= `XTSE_DIR_SEL_HI);

  // --------------------------------------------------------------------------
  // Operation results
  // --------------------------------------------------------------------------

  // Results of every operation are formed together; the opcode picks one.
  wire [7:0]  xlw_res = wreg_q ^ instr[7:0];
  wire [7:0]  xwf_res = wreg_q ^ fval;
  // Subtraction adds the complement of W plus one; the carry out is then the inverse
  // of a borrow, which is exactly the carry the subtract must leave behind.
  wire [8:0]  sub_sum = {1'b0, fval} + {1'b0, ~wreg_q} + 9'h001;
  wire [4:0]  sub_lo  = {1'b0, fval[3:0]} + {1'b0, ~wreg_q[3:0]} + 5'h01;
  wire [7:0]  sub_res = sub_sum[7:0];

  // Direction outputs come straight from their flops, so the pins never see a glitch.
  assign tris5_dir = tris5_q;
  assign tris6_dir = tris6_q;
  assign tris7_dir = tris7_q;

  // --------------------------------------------------------------------------
  // Register and execution process
  // --------------------------------------------------------------------------

  // Every instruction retires in the cycle its write is performed, so nothing stalls.
  always @(posedge aclk) begin
    if (!aresetn) begin
      wreg_q    <= `XTSE_RST_WREG;
      status_q  <= `XTSE_RST_STATUS;
      // All ones leaves every pin an input until software has chosen a direction.
      tris5_q   <= `XTSE_RST_DIR;
      tris6_q   <= `XTSE_RST_DIR;
      tris7_q   <= `XTSE_RST_DIR;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `XTSE_RESP_OKAY;
      for (i = 0; i < 32; i = i + 1) begin
        file_q[i] <= `XTSE_RST_FILE;
      end
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= is_mapped(wa) ? `XTSE_RESP_OKAY : `XTSE_RESP_SLVERR;
        // Plain register writes use byte lane 0 only; the upper lanes hold nothing.
        // A write with lane 0 off still answers OKAY and changes nothing.
        if (wstrb_q[0]) begin
          if (wa == `XTSE_OFF_WREG) begin
            wreg_q <= wdata_q[7:0];
          end
          if (wa == `XTSE_OFF_STATUS) begin
            status_q <= wdata_q[7:0];
          end
          if (wa == `XTSE_OFF_TRIS5) begin
            tris5_q <= wdata_q[7:0];
          end
          if (wa == `XTSE_OFF_TRIS6) begin
            tris6_q <= wdata_q[7:0];
          end
          if (wa == `XTSE_OFF_TRIS7) begin
            tris7_q <= wdata_q[7:0];
          end
          if (is_file(wa)) begin
            file_q[wfile] <= wdata_q[7:0];
          end
        end
      end
      // A bus store and an issued word never share a cycle, since only one write is
      // under way, so the flag updates below cannot collide with a store to status.
      if (issue) begin
        status_q[`XTSE_ST_UNSUP] <= ~(op_xlw | op_xwf | op_sub | op_dir);
        if (op_xlw) begin
          wreg_q                  <= xlw_res;
          status_q[`XTSE_ST_ZERO] <= (xlw_res == 8'h00);
        end else if (op_xwf) begin
          if (dsel) begin
            file_q[fsel] <= xwf_res;
          end else begin
            wreg_q <= xwf_res;
          end
          status_q[`XTSE_ST_ZERO] <= (xwf_res == 8'h00);
        end else if (op_sub) begin
          if (dsel) begin
            file_q[fsel] <= sub_res;
          end else begin
            wreg_q <= sub_res;
          end
          status_q[`XTSE_ST_CARRY]  <= sub_sum[8];
          status_q[`XTSE_ST_DCARRY] <= sub_lo[4];
          status_q[`XTSE_ST_ZERO]   <= (sub_res == 8'h00);
        end else if (op_dir) begin
          case (instr[2:0])
            3'h5: begin
              tris5_q <= wreg_q;
            end
            3'h6: begin
              tris6_q <= wreg_q;
            end
            3'h7: begin
              tris7_q <= wreg_q;
            end
            default: begin
              tris5_q <= tris5_q;
            end
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // The address is decoded straight off the bus so the data can be latched on the taking edge.
  wire [7:0] ra    = {s_axi_araddr[7:2], 2'b00};
  wire [4:0] rfile = ra[6:2] - 5'h10;
  reg  [7:0] rd_byte;

  // Read mux; the instruction register reads back as zero since it only issues.
  always @* begin
    rd_byte = 8'h00;
    if (is_file(ra)) begin
      rd_byte = file_q[rfile];
    end else begin
      case (ra)
        `XTSE_OFF_WREG:   rd_byte = wreg_q;
        `XTSE_OFF_STATUS: rd_byte = status_q;
        `XTSE_OFF_TRIS5:  rd_byte = tris5_q;
        `XTSE_OFF_TRIS6:  rd_byte = tris6_q;
        `XTSE_OFF_TRIS7:  rd_byte = tris7_q;
        default:          rd_byte = 8'h00;
      endcase
    end
  end

  // Registers are a byte wide, so lanes 1 to 3 of the read data are always zero.
  // Read data is registered on the same edge that takes the address.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `XTSE_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h00_0000, rd_byte};
        rresp_q  <= is_mapped(ra) ? `XTSE_RESP_OKAY : `XTSE_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule // xtse_exec

// File: test/xtse_checker.sv
// Checker of bus handshakes and direction outputs of the execution slice.
`timescale 1ns/100ps
module xtse_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [7:0]  tris5_dir,
  input wire [7:0]  tris6_dir,
  input wire [7:0]  tris7_dir
);
  // ----------
  // Checks
  // ----------
  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write answers two edges after both halves are taken, a read one edge after its address.
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  // Answers stand until taken.
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
  a_wr_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_rd_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  // Direction registers move only as a write completes, and one port at a time.
  a_dir_cause:
    assert property (!$stable({tris5_dir, tris6_dir, tris7_dir}) |-> $rose(s_axi_bvalid))
      else $error("direction change without write");
  a_dir_one:
    assert property ($onehot0({!$stable(tris5_dir), !$stable(tris6_dir), !$stable(tris7_dir)}))
      else $error("several ports changed");
endmodule // xtse_checker

bind xtse_exec xtse_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tris5_dir(tris5_dir),
  .tris6_dir(tris6_dir), .tris7_dir(tris7_dir));

// File: test/xtse_port_model.sv
// Pad model of the three ports behind the direction registers.
`timescale 1ns/100ps
module xtse_port_model (
  input  wire [7:0]  tris5_dir,
  input  wire [7:0]  tris6_dir,
  input  wire [7:0]  tris7_dir,
  output wire [23:0] pad_level
);
  // ----------
  // Pads
  // ----------
  // Input pins rise to the pull-up; output pins show a cleared latch, as no data path is modelled.
  assign pad_level = {tris7_dir, tris6_dir, tris5_dir};
endmodule // xtse_port_model

// File: test/tb.sv
// Self-checking bench that runs the four instructions over the register bus.
`timescale 1ns/100ps
`include "xtse_consts.vh"
module tb;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg  [7:0]  araddr = 8'h00;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [7:0]  t5, t6, t7;
  wire [23:0] pads;
  reg  [31:0] rd_v;
  reg  [1:0]  rd_r;
  reg  [1:0]  wr_r;
  integer     n_fail = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     i;
  // ----------
  // Harness
  // ----------
  // Clock of 100 ns period.
  always #50 aclk = ~aclk;
  xtse_exec dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tris5_dir(t5), .tris6_dir(t6), .tris7_dir(t7));
  xtse_port_model u_pads (.tris5_dir(t5), .tris6_dir(t6), .tris7_dir(t7), .pad_level(pads));
  // Compare, bus cycles and verdict; ready is held back one cycle to exercise stalls.
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) bready <= ~bready;
      end while (!(bvalid && bready));
      wr_r = bresp;
    end
  endtask
  task rd(input [7:0] a);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) rready <= ~rready;
      end while (!(rvalid && rready));
      rd_v = rdata;
      rd_r = rresp;
    end
  endtask
  task rc(input string nm, input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(nm, rd_v, e);
    end
  endtask
  task ex(input [11:0] c);
    wr(`XTSE_OFF_INSTR, {20'h0, c});
  endtask
  function [7:0] fa(input [4:0] n);
    fa = `XTSE_OFF_FILE_LO + {1'b0, n, 2'b00};
  endfunction
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // A hang is cut short far beyond the two hundred or so cycles the tests need.
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  // ----------
  // Tests
  // ----------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("dir reset", pads, 24'hffffff);
    rc("status reset", `XTSE_OFF_STATUS, 0);
    rc("unmapped", 8'h20, 0);
    chk("unmapped resp", rd_r, `XTSE_RESP_SLVERR);
    wr(8'h20, 32'h55);
    chk("unmapped wr resp", wr_r, `XTSE_RESP_SLVERR);
    $display("test reset done");
    wr(`XTSE_OFF_STATUS, 1);
    chk("wr resp", wr_r, `XTSE_RESP_OKAY);
    wr(`XTSE_OFF_WREG, 8'hb5);
    ex(12'hfaf);
    rc("xlit w", `XTSE_OFF_WREG, 8'h1a);
    rc("xlit flags", `XTSE_OFF_STATUS, 1);
    ex(12'hf1a);
    rc("xlit zero", `XTSE_OFF_STATUS, 5);
    ex(12'hfff);
    rc("xlit max", `XTSE_OFF_WREG, 8'hff);
    $display("test literal done");
    wr(fa(31), 8'haf);
    wr(`XTSE_OFF_WREG, 8'hb5);
    ex(12'h1bf);
    rc("xf file", fa(31), 8'h1a);
    rc("xf w kept", `XTSE_OFF_WREG, 8'hb5);
    ex(12'h19f);
    rc("xf w", `XTSE_OFF_WREG, 8'haf);
    rc("xf file kept", fa(31), 8'h1a);
    $display("test file xor done");
    for (i = 1; i < 4; i = i + 1) begin
      wr(fa(5), i);
      wr(`XTSE_OFF_WREG, 2);
      ex(12'h0a5);
      rc("sub res", fa(5), (i - 2) & 8'hff);
      rd(`XTSE_OFF_STATUS);
      chk("sub flags", rd_v & 32'h5, {(i == 2), 1'b0, (i >= 2)});
    end
    ex(12'h085);
    rc("sub to w", `XTSE_OFF_WREG, 8'hff);
    rc("sub file kept", fa(5), 8'h01);
    $display("test subtract done");
    for (i = 5; i < 8; i = i + 1) begin
      wr(`XTSE_OFF_WREG, 8'ha0 + i);
      ex(i[11:0]);
    end
    chk("dir load", pads, 24'ha7a6a5);
    ex(12'h004);
    ex(12'h805);
    chk("dir kept", pads, 24'ha7a6a5);
    rd(`XTSE_OFF_STATUS);
    chk("unsupported", rd_v[7], 1);
    $display("test dirload done");
    final_report;
  end
endmodule // tb
